/* File: asr_pkg.sv */
// Package with pin bundles, states and timing counts for the SRAM host.
package asr_pkg;

  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam int BYTE_W = 8;
  localparam int WORDS = 65536;
  localparam int CLK_PS = 10000;

  // Device timing figures in picoseconds, fastest grade.
  localparam int T_AA_PS = 8000;
  localparam int T_ACE_PS = 8000;
  localparam int T_DOE_PS = 4000;
  localparam int T_DBE_PS = 4000;
  localparam int T_OHA_PS = 3000;
  localparam int T_SA_PS = 0;
  localparam int T_AW_PS = 6000;
  localparam int T_HA_PS = 0;
  localparam int T_SD_PS = 4000;
  localparam int T_HD_PS = 0;
  localparam int T_SCE_PS = 7000;
  localparam int T_BW_PS = 8000;
  localparam int T_HZ_PS = 4000;

  function automatic int up_cyc(input int ps);
    int c;
    c = (ps + CLK_PS - 1) / CLK_PS;
    return (c < 1) ? 1 : c;
  endfunction

  // Read wait: worst of address, select, output and lane access.
  localparam int RD_CYC = up_cyc(T_AA_PS);
  // Write pulse: longest of the setup-to-end figures.
  localparam int WR_CYC = up_cyc(T_BW_PS);
  localparam int SD_CYC = up_cyc(T_SD_PS);
  // Turnaround after a read so the device floats before we drive.
  localparam int TA_CYC = up_cyc(T_HZ_PS);
  localparam int HOLD_CYC = up_cyc(T_HA_PS);
  localparam int CNT_W = 4;

  localparam logic [1:0] LANES_RESET = 2'h3;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [1:0] lane_en;
    logic write;
  } asr_req_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic chip_sel_n;
    logic out_en_n;
    logic wr_strobe_n;
    logic low_lane_en_n;
    logic high_lane_en_n;
  } asr_pins_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_RD = 3'h1,
    ST_RD_DONE = 3'h3,
    ST_TURN = 3'h2,
    ST_WR_SETUP = 3'h6,
    ST_WR = 3'h7,
    ST_WR_HOLD = 3'h5
  } asr_state_t;

endpackage

/* File: asr_sync.sv */
// Three-stage synchroniser with agreement of the last two stages.
`timescale 1ns/100ps
`default_nettype none
module asr_sync #(
  parameter int W = 16
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;
  logic [W-1:0] q_ff;
  logic [W-1:0] nxt_q;

  // Each bit updates only when the two settled stages agree.
  genvar i;
  for (i = 0; i < W; i++) begin : g_bit
    assign nxt_q[i] = (s2_ff[i] == s3_ff[i]) ? s3_ff[i] : q_ff[i];
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
      q_ff <= '0;
    end else begin
      s1_ff <= d;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      q_ff <= nxt_q;
    end
  end

  assign q = q_ff;
endmodule
`default_nettype wire

/* File: asr_host.sv */
// Host controller driving a 64K by 16 asynchronous SRAM with byte lanes.
`timescale 1ns/100ps
`default_nettype none
// Contract
// RULE1: Read both lanes when both enabled.
// RULE2: Low lane read, upper lane floats.
// RULE3: High lane read, lower lane floats.
// RULE4: Write stores both lanes regardless of OE.
// RULE5: Low-only write keeps upper byte.
// RULE6: High-only write keeps lower byte.
// RULE7: Chip select high floats, powers down.
// RULE8: OE high or lanes off: no data.
// RULE9: Write starts at overlap of lows.
// RULE10: Write ends at first rising control.
// RULE11: Select and strobe rising together stays floating.
// RULE12: Read data valid 8 ns after address.
// RULE13: Old data held 3 ns after address.
// RULE14: Read data valid 8 ns after select.
// RULE15: Read data valid 4 ns after OE.
// RULE16: Lane data valid 4 ns after enable.
// RULE17: Address stable at write start, held after.
// RULE18: Address stable 6 ns before write end.
// RULE19: Data set up 4 ns, held 0 ns.
// RULE20: Select low 7 ns before write end.
// RULE21: Lane enable 8 ns before write end.
// RULE22: Memory is 65,536 words of 16 bits.
// RULE23: Contents undefined until first written.
module asr_host (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // User request side
  input wire logic req_valid,
  output logic req_ready,
  input wire asr_pkg::asr_req_t req,
  // User answer side
  output logic rsp_valid,
  output logic [asr_pkg::DATA_W-1:0] rsp_data,
  // SRAM control and address pins
  output asr_pkg::asr_pins_t pins,
  // SRAM data pins, split into input, output and enables
  input wire logic [asr_pkg::DATA_W-1:0] dq_in,
  output logic [asr_pkg::DATA_W-1:0] dq_out,
  output logic [1:0] dq_oe
);
  localparam logic [asr_pkg::CNT_W-1:0] RD_N =
    asr_pkg::CNT_W'(asr_pkg::RD_CYC);
  localparam logic [asr_pkg::CNT_W-1:0] WR_N =
    asr_pkg::CNT_W'(asr_pkg::WR_CYC);
  localparam logic [asr_pkg::CNT_W-1:0] TA_N =
    asr_pkg::CNT_W'(asr_pkg::TA_CYC);
  localparam logic [asr_pkg::CNT_W-1:0] HOLD_N =
    asr_pkg::CNT_W'(asr_pkg::HOLD_CYC);
  localparam logic [asr_pkg::CNT_W-1:0] CNT_ONE =
    {{(asr_pkg::CNT_W-1){1'h0}}, 1'h1};
  localparam int SYNC_EXTRA = 3;

  asr_pkg::asr_state_t state_ff;
  asr_pkg::asr_state_t nxt_state;
  logic [asr_pkg::CNT_W-1:0] cnt_ff;
  logic [asr_pkg::CNT_W-1:0] nxt_cnt;
  asr_pkg::asr_req_t cur_ff;
  logic [asr_pkg::DATA_W-1:0] rdata_ff;
  logic rsp_valid_ff;
  logic [asr_pkg::DATA_W-1:0] dq_sync;

  logic cnt_done;
  logic take;
  logic in_read;
  logic in_write;
  logic wr_pulse;
  logic drive_data;
  logic [asr_pkg::DATA_W-1:0] lane_mask;
  asr_pkg::asr_req_t nxt_cur;
  logic nxt_sel_n;
  logic nxt_oe_n;
  logic nxt_we_n;
  logic nxt_lo_n;
  logic nxt_hi_n;
  asr_pkg::asr_pins_t nxt_pins;
  asr_pkg::asr_pins_t pins_ff;
  logic [1:0] nxt_dq_oe;
  logic [1:0] dq_oe_ff;

  // Pin data passes the synchroniser, so the read wait adds its latency.
  asr_sync #(
    .W(asr_pkg::DATA_W)
  ) u_sync (
    .core_clk(core_clk),
    .resetn(resetn),
    .d(dq_in),
    .q(dq_sync)
  );

  assign cnt_done = (cnt_ff == '0);
  assign req_ready = (state_ff == asr_pkg::ST_IDLE);
  assign take = req_valid && req_ready;
  assign nxt_cur = take ? req : cur_ff;
  // Pins decode the next state into flip-flops: a state change that
  // flips two code bits would otherwise glitch output enable.
  assign in_read = (nxt_state == asr_pkg::ST_RD) ||
    (nxt_state == asr_pkg::ST_RD_DONE);
  assign in_write = (nxt_state == asr_pkg::ST_WR_SETUP) ||
    (nxt_state == asr_pkg::ST_WR) || (nxt_state == asr_pkg::ST_WR_HOLD);
  // RULE9: strobe low only inside the write pulse.
  assign wr_pulse = (nxt_state == asr_pkg::ST_WR);
  // RULE19: data driven across setup, pulse and hold.
  assign drive_data = in_write;

  // RULE7: select high whenever idle or turning round.
  assign nxt_sel_n = !(in_read || in_write);
  // RULE4: output enable stays high during writes.
  assign nxt_oe_n = !in_read;
  // RULE11: strobe rises a cycle before select, so no read glitch.
  assign nxt_we_n = !wr_pulse;
  // RULE21: lane enables frame the whole access.
  assign nxt_lo_n = !((in_read || in_write) && nxt_cur.lane_en[0]);
  assign nxt_hi_n = !((in_read || in_write) && nxt_cur.lane_en[1]);
  // RULE17: address held from setup through hold.
  assign nxt_pins = '{addr: nxt_cur.addr, chip_sel_n: nxt_sel_n,
    out_en_n: nxt_oe_n, wr_strobe_n: nxt_we_n, low_lane_en_n: nxt_lo_n,
    high_lane_en_n: nxt_hi_n};
  assign pins = pins_ff;

  assign dq_out = cur_ff.wdata;
  // RULE5: only enabled lanes are driven.
  assign nxt_dq_oe = drive_data ? nxt_cur.lane_en : 2'h0;
  assign dq_oe = dq_oe_ff;

  // RULE2: unenabled lanes return zero to the user.
  assign lane_mask = {{asr_pkg::BYTE_W{cur_ff.lane_en[1]}},
    {asr_pkg::BYTE_W{cur_ff.lane_en[0]}}};

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff - CNT_ONE;
    if (cnt_done) begin
      nxt_cnt = cnt_ff;
    end
    case (state_ff)
      asr_pkg::ST_IDLE: begin
        if (take && req.write) begin
          nxt_state = asr_pkg::ST_WR_SETUP;
          nxt_cnt = '0;
        end else if (take) begin
          // RULE12: wait access time plus synchroniser depth.
          nxt_state = asr_pkg::ST_RD;
          nxt_cnt = RD_N + asr_pkg::CNT_W'(SYNC_EXTRA);
        end
      end
      asr_pkg::ST_RD: begin
        if (cnt_done) begin
          nxt_state = asr_pkg::ST_RD_DONE;
        end
      end
      asr_pkg::ST_RD_DONE: begin
        // RULE13: bus released before the address moves.
        nxt_state = asr_pkg::ST_TURN;
        nxt_cnt = TA_N;
      end
      asr_pkg::ST_TURN: begin
        if (cnt_done) begin
          nxt_state = asr_pkg::ST_IDLE;
        end
      end
      asr_pkg::ST_WR_SETUP: begin
        // RULE20: select and lanes low before strobe falls.
        nxt_state = asr_pkg::ST_WR;
        nxt_cnt = WR_N - CNT_ONE;
      end
      asr_pkg::ST_WR: begin
        // RULE18: pulse spans the longest setup to end.
        if (cnt_done) begin
          nxt_state = asr_pkg::ST_WR_HOLD;
          nxt_cnt = HOLD_N - CNT_ONE;
        end
      end
      asr_pkg::ST_WR_HOLD: begin
        // RULE10: strobe ends write; hold one cycle more.
        if (cnt_done) begin
          nxt_state = asr_pkg::ST_IDLE;
        end
      end
      default: begin
        nxt_state = asr_pkg::ST_IDLE;
        nxt_cnt = '0;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      state_ff <= asr_pkg::ST_IDLE;
      cnt_ff <= '0;
      cur_ff <= '{addr: '0, wdata: '0, lane_en: asr_pkg::LANES_RESET,
        write: 1'h0};
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      if (take) begin
        cur_ff <= req;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      pins_ff <= '{addr: '0, chip_sel_n: 1'h1, out_en_n: 1'h1,
        wr_strobe_n: 1'h1, low_lane_en_n: 1'h1, high_lane_en_n: 1'h1};
      dq_oe_ff <= 2'h0;
    end else begin
      pins_ff <= nxt_pins;
      dq_oe_ff <= nxt_dq_oe;
    end
  end

  // RULE1: capture word while all read controls are low.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      rdata_ff <= '0;
      rsp_valid_ff <= 1'h0;
    end else begin
      rsp_valid_ff <= (state_ff == asr_pkg::ST_RD_DONE);
      if (state_ff == asr_pkg::ST_RD_DONE) begin
        rdata_ff <= dq_sync & lane_mask;
      end
    end
  end

  assign rsp_valid = rsp_valid_ff;
  assign rsp_data = rdata_ff;
endmodule
`default_nettype wire

/* File: asr_mem_model.sv */
// Behavioural model of the 64K by 16 static memory with byte lanes.
`timescale 1ns/100ps
`default_nettype none
module asr_mem_model (
  // Clock for the floating-lane pattern
  input wire logic core_clk,
  // Memory pins
  input wire asr_pkg::asr_pins_t pins,
  input wire logic [15:0] dq_out,
  input wire logic [1:0] dq_oe,
  output logic [15:0] dq_in
);
  logic [15:0] mem [0:65535];
  logic tgl = 1'h0;
  wire sel = !pins.chip_sel_n;
  wire wr = sel && !pins.wr_strobe_n;
  wire [1:0] ln = ~{pins.high_lane_en_n, pins.low_lane_en_n};
  wire [1:0] drv = (sel && !wr && !pins.out_en_n) ? ln : 2'h0;
  wire [7:0] flt = {8{tgl}};
  wire [15:0] bus = {dq_oe[1] ? dq_out[15:8] : flt,
    dq_oe[0] ? dq_out[7:0] : flt};
  // A released lane changes every cycle so a stale sample cannot pass.
  always @(posedge core_clk) tgl <= !tgl;
  // Data at once, inside all limits.
  assign dq_in[7:0] = drv[0] ? mem[pins.addr][7:0] : ~flt;
  assign dq_in[15:8] = drv[1] ? mem[pins.addr][15:8] : ~flt;
  // Lanes stored while the lows overlap.
  always @* begin
    if (wr && ln[0]) mem[pins.addr][7:0] = bus[7:0];
    if (wr && ln[1]) mem[pins.addr][15:8] = bus[15:8];
  end
endmodule
`default_nettype wire

/* File: asr_host_sva.sv */
// Checker of the SRAM host pin sequencing.
`timescale 1ns/100ps
`default_nettype none
module asr_host_sva (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // User side
  input wire logic req_valid,
  input wire logic req_ready,
  input wire asr_pkg::asr_req_t req,
  input wire logic rsp_valid,
  input wire logic [15:0] rsp_data,
  // Memory side
  input wire asr_pkg::asr_pins_t pins,
  input wire logic [15:0] dq_in,
  input wire logic [15:0] dq_out,
  input wire logic [1:0] dq_oe
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  wire take = req_valid && req_ready;
  wire [1:0] lan = ~{pins.high_lane_en_n, pins.low_lane_en_n};
  idle_float_a:
    assert property (req_ready |-> pins.chip_sel_n && dq_oe == 2'h0)
    else $error("pins active while idle");
  read_ctl_a:
    assert property (take && !req.write |=> !pins.chip_sel_n &&
      !pins.out_en_n && pins.wr_strobe_n && lan == $past(req.lane_en))
    else $error("read controls wrong");
  read_rsp_a:
    assert property (take && !req.write |-> ##7 rsp_valid)
    else $error("read answer late");
  no_clash_a:
    assert property (!pins.out_en_n |-> dq_oe == 2'h0)
    else $error("host drives during read");
  wr_pulse_a:
    assert property (take && req.write |-> ##2 !pins.wr_strobe_n
      ##1 (pins.wr_strobe_n && !pins.chip_sel_n))
    else $error("write pulse wrong");
  wr_ctx_a:
    assert property (!pins.wr_strobe_n |-> !pins.chip_sel_n &&
      !$past(pins.chip_sel_n) && lan == $past(lan) && dq_oe == lan)
    else $error("write context wrong");
  addr_hold_a:
    assert property (!pins.chip_sel_n && !$past(pins.chip_sel_n)
      |-> $stable(pins.addr))
    else $error("address moved while selected");
  data_hold_a:
    assert property ($rose(pins.wr_strobe_n) |-> $stable(dq_out) &&
      $stable(dq_oe) && !pins.chip_sel_n)
    else $error("write data not held");
  rsp_pulse_a:
    assert property (rsp_valid |=> !rsp_valid)
    else $error("answer longer than one cycle");
endmodule
bind asr_host asr_host_sva asr_host_sva_i (.core_clk(core_clk),
  .resetn(resetn), .req_valid(req_valid), .req_ready(req_ready),
  .req(req), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .pins(pins),
  .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe));
`default_nettype wire

/* File: asr_host_bench.sv */
// Self-checking bench of the SRAM host against a memory model.
`timescale 1ns/100ps
`default_nettype none
module asr_host_bench;
  logic core_clk, resetn, req_valid, req_ready, rsp_valid;
  asr_pkg::asr_req_t req;
  asr_pkg::asr_pins_t pins;
  logic [15:0] rsp_data, dq_in, dq_out;
  logic [1:0] dq_oe;
  int err_total = 0;
  int n_checks = 0;
  asr_host asr_host_i (.core_clk(core_clk), .resetn(resetn),
    .req_valid(req_valid), .req_ready(req_ready), .req(req),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .pins(pins),
    .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe));
  asr_mem_model asr_mem_model_i (.core_clk(core_clk), .pins(pins),
    .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in));
  task automatic give_verdict;
    if (err_total == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Waits at falling edges so the sample never races the clock edge.
  task automatic wait_on(input logic rsp);
    int n;
    n = 0;
    @(negedge core_clk);
    while ((rsp ? rsp_valid : req_ready) !== 1'h1) begin
      n++;
      if (n > 30) begin
        err_total++;
        give_verdict;
      end
      @(negedge core_clk);
    end
  endtask
  task automatic xfer(input logic w, input logic [15:0] a,
    input logic [15:0] d, input logic [1:0] ln, input logic [15:0] exp);
    @(posedge core_clk);
    req_valid <= 1'h1;
    req <= '{addr: a, wdata: d, lane_en: ln, write: w};
    wait_on(1'h0);
    @(posedge core_clk);
    req_valid <= 1'h0;
    if (!w) begin
      wait_on(1'h1);
      chk(rsp_data, exp);
    end
  endtask
  task automatic s_full;
    xfer(1'h1, 16'h0000, 16'h1234, 2'h3, 16'h0000);
    xfer(1'h0, 16'h0000, 16'h0000, 2'h3, 16'h1234);
  endtask
  task automatic s_lanes;
    xfer(1'h1, 16'h0000, 16'hFFCD, 2'h1, 16'h0000);
    xfer(1'h0, 16'h0000, 16'h0000, 2'h3, 16'h12CD);
    xfer(1'h1, 16'h0000, 16'h56EE, 2'h2, 16'h0000);
    xfer(1'h0, 16'h0000, 16'h0000, 2'h3, 16'h56CD);
  endtask
  task automatic s_part;
    xfer(1'h0, 16'h0000, 16'h0000, 2'h1, 16'h00CD);
    xfer(1'h0, 16'h0000, 16'h0000, 2'h2, 16'h5600);
    xfer(1'h0, 16'h0000, 16'h0000, 2'h0, 16'h0000);
    xfer(1'h1, 16'h0000, 16'hFFFF, 2'h0, 16'h0000);
    xfer(1'h0, 16'h0000, 16'h0000, 2'h3, 16'h56CD);
  endtask
  task automatic s_top;
    xfer(1'h1, 16'hFFFF, 16'hA55A, 2'h3, 16'h0000);
    xfer(1'h0, 16'hFFFF, 16'h0000, 2'h3, 16'hA55A);
    xfer(1'h0, 16'h0000, 16'h0000, 2'h3, 16'h56CD);
  endtask
  initial begin
    core_clk = 1'h0;
    forever #5 core_clk = !core_clk;
  end
  initial begin
    resetn = 1'h0;
    req_valid = 1'h0;
    req = '0;
    repeat (8) @(posedge core_clk);
    resetn <= 1'h1;
    s_full;
    s_lanes;
    s_part;
    s_top;
    give_verdict;
  end
endmodule
`default_nettype wire
